/* File: core/mbh_pkg.sv */
// package for the memory bus hold handshake block
// Operation
// - finish pending accesses before acknowledging release
// - inhibit bit set withholds release indefinitely
// - float select 0 keeps clock toggling
// - float select 1 floats clock in hold
// - float bus at least two periods after request
// - acknowledge low within two periods after float
// - drive bus two to seven periods after release
// - acknowledge high within two periods after drive
// - clock float and redrive timed like bus
// - wide bus float set includes all listed pins
// - narrow bus float set includes all listed pins
// - pending request updated on output clock rise
// - shared strobes act as sdram strobes
// - periods counted on selected interface clock
package mbh_pkg;
    // interface clock source selection
    typedef enum logic [1:0] {
        MBH_SRC_PIN  = 2'h0,
        MBH_SRC_DIV4 = 2'h1,
        MBH_SRC_DIV6 = 2'h2
    } mbh_src_t;

    // hold sequence states, gray along the usual path except redrive back to drive
    typedef enum logic [2:0] {
        MBH_DRIVE   = 3'h0,
        MBH_DRAIN   = 3'h1,
        MBH_FLOAT   = 3'h3,
        MBH_HOLD    = 3'h2,
        MBH_REDRIVE = 3'h6
    } mbh_state_t;

    // configuration from the global control register
    typedef struct packed {
        logic     releaseInhibit;
        logic     clockOutFloatSelect;
        logic     wideBus;
        mbh_src_t clkSource;
    } mbh_cfg_t;

    // handshake status toward the pins
    typedef struct packed {
        logic busFloat;
        logic clockFloat;
        logic busReleaseAck_n;
    } mbh_stat_t;

    localparam int unsigned MBH_DIV4       = 4;
    localparam int unsigned MBH_DIV6       = 6;
    localparam logic [2:0]  MBH_FLOAT_WAIT = 3'h2;
    localparam logic [2:0]  MBH_ACK_WAIT   = 3'h1;
    localparam logic [2:0]  MBH_DRIVE_WAIT = 3'h2;
    localparam logic [2:0]  MBH_DRIVE_MAX  = 3'h7;
    localparam logic [3:0]  MBH_DIV_RESET  = 4'h0;
    localparam int unsigned MBH_WIDE_PINS  = 4 + 8 + 64 + 20 + 3 + 3;
    localparam int unsigned MBH_NARROW_PINS = 4 + 2 + 16 + 20 + 3 + 2;
endpackage : mbh_pkg

/* File: core/mbh_tick_gen.sv */
// interface clock tick generator: pin edge or divided core clock
module mbh_tick_gen
    import mbh_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     arst_n,
    input  wire mbh_src_t clkSource,
    input  wire logic     memoryClockIn,
    output logic          tick
);
    logic       pinMeta;
    logic       pinSync;
    logic       pinLast;
    logic [3:0] divCount;
    logic [3:0] divLast;
    wire        pinRise = pinSync & ~pinLast;
    wire        divWrap;

    // pin clock passes two flops before the edge detector
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
            pinLast <= 1'b0;
        end
        else
        begin
            pinMeta <= memoryClockIn;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    assign divLast = (clkSource == MBH_SRC_DIV6) ? 4'(MBH_DIV6 - 1)
                                                 : 4'(MBH_DIV4 - 1);
    assign divWrap = (divCount >= divLast);

    // core clock divider for the div4 and div6 sources
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            divCount <= MBH_DIV_RESET;
        else
            divCount <= divWrap ? MBH_DIV_RESET : divCount + 4'h1;
    end

    assign tick = (clkSource == MBH_SRC_PIN) ? pinRise : divWrap;
endmodule : mbh_tick_gen

/* File: core/mbh_hold_ctrl.sv */
// hold handshake controller of the external memory interface
module mbh_hold_ctrl
    import mbh_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     arst_n,
    input  wire mbh_cfg_t cfg,
    input  wire logic     memoryClockIn,
    input  wire logic     busReleaseReq_n,
    input  wire logic     accessPending,
    input  wire logic     accessActive,
    input  wire logic     sdramAccess,
    input  wire logic     readStrobe,
    input  wire logic     writeStrobe,
    input  wire logic     outputStrobe,
    output logic          columnStrobe,
    output logic          sdramWriteEnable,
    output logic          rowStrobe,
    output logic          memoryClockOut,
    output logic          memoryClockOutEn,
    output logic          busDriveEn,
    output logic [MBH_WIDE_PINS-1:0] pinDriveEn,
    output logic          busReleaseAck_n,
    output logic          pendingAccessRequest,
    output mbh_stat_t     status
);
    logic       tick;
    logic       reqMeta;
    logic       reqSync;
    logic [2:0] count;
    logic       clkOut;
    logic       ackReg;
    logic       floatReg;
    logic       clkFloatReg;
    logic       pendReg;
    logic [2:0] next_count;
    mbh_state_t state;
    mbh_state_t next_state;

    mbh_tick_gen u_tick (
        .clk           (clk),
        .arst_n        (arst_n),
        .clkSource     (cfg.clkSource),
        .memoryClockIn (memoryClockIn),
        .tick          (tick)
    );

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reqMeta <= 1'b1;
            reqSync <= 1'b1;
        end
        else
        begin
            reqMeta <= busReleaseReq_n;
            reqSync <= reqMeta;
        end
    end

    wire holdWanted = ~reqSync & ~cfg.releaseInhibit;
    wire drained    = ~accessPending & ~accessActive;
    wire cntDone    = (count == 3'h0);

    // next state; steps only on interface ticks
    always_comb
    begin
        next_state = state;
        next_count = count;
        if (tick)
        begin
            if (!cntDone)
                next_count = count - 3'h1;
            case (state)
                MBH_DRIVE:
                begin
                    if (holdWanted)
                    begin
                        next_state = MBH_DRAIN;
                        next_count = MBH_FLOAT_WAIT - 3'h1;
                    end
                end
                MBH_DRAIN:
                begin
                    // drain then float after two periods
                    // inhibit or withdrawal both abort the release
                    if (!holdWanted)
                        next_state = MBH_DRIVE;
                    else if (drained && cntDone)
                    begin
                        next_state = MBH_FLOAT;
                        next_count = MBH_ACK_WAIT;
                    end
                end
                MBH_FLOAT:
                begin
                    if (cntDone || count == 3'h1)
                        next_state = MBH_HOLD;
                end
                MBH_HOLD:
                begin
                    if (reqSync)
                    begin
                        next_state = MBH_REDRIVE;
                        next_count = MBH_DRIVE_WAIT - 3'h1;
                    end
                end
                MBH_REDRIVE:
                begin
                    // ack removed a period after drive
                    if (cntDone)
                        next_state = MBH_DRIVE;
                end
                default:
                    next_state = MBH_DRIVE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= MBH_DRIVE;
            count <= 3'h0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    // registered pin controls; ack trails float by one tick
    // bus stays floated through redrive so it never glitches back
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            floatReg    <= 1'b0;
            ackReg      <= 1'b1;
            clkFloatReg <= 1'b0;
        end
        else if (tick)
        begin
            floatReg    <= (next_state == MBH_FLOAT) ||
                           (next_state == MBH_HOLD) ||
                           (next_state == MBH_REDRIVE);
            // ack held low one more tick after the bus is driven again
            ackReg      <= ~((next_state == MBH_HOLD) ||
                             (next_state == MBH_REDRIVE) ||
                             (state == MBH_REDRIVE));
            clkFloatReg <= cfg.clockOutFloatSelect &&
                           ((next_state == MBH_FLOAT) ||
                            (next_state == MBH_HOLD) ||
                            (next_state == MBH_REDRIVE));
        end
    end

    // output memory clock toggles every tick
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            clkOut <= 1'b0;
        else if (tick)
            clkOut <= ~clkOut;
    end

    // pending request sampled on output clock rise
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pendReg <= 1'b0;
        else if (tick && !clkOut)
            pendReg <= accessPending | accessActive;
    end

    // float set sized by bus width
    genvar gi;
    generate
        for (gi = 0; gi < MBH_WIDE_PINS; gi++)
        begin : g_pin
            if (gi < MBH_NARROW_PINS)
                assign pinDriveEn[gi] = ~floatReg;
            else
                assign pinDriveEn[gi] = ~floatReg & cfg.wideBus;
        end
    endgenerate

    assign columnStrobe     = sdramAccess ? readStrobe   : 1'b1;
    assign sdramWriteEnable = sdramAccess ? writeStrobe  : 1'b1;
    assign rowStrobe        = sdramAccess ? outputStrobe : 1'b1;

    assign busDriveEn           = ~floatReg;
    assign busReleaseAck_n      = ackReg;
    assign memoryClockOut       = clkOut;
    assign memoryClockOutEn     = ~clkFloatReg;
    assign pendingAccessRequest = pendReg;
    assign status = '{busFloat: floatReg, clockFloat: clkFloatReg,
                      busReleaseAck_n: ackReg};

    ack_float_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(ackReg) |-> floatReg && $past(floatReg))
        else $error("ack low while bus driven");
    // no float under inhibit from drive
    inhibit_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == MBH_DRIVE && cfg.releaseInhibit) |=>
        state == MBH_DRIVE) else $error("released while inhibited");
    drain_first_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == MBH_DRAIN && next_state == MBH_FLOAT) |-> drained)
        else $error("floated with access pending");
    // clock keeps driving when not selected
    clk_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
        !cfg.clockOutFloatSelect && $stable(cfg.clockOutFloatSelect)
        |-> ##1 memoryClockOutEn) else $error("clock floated");
    ack_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(ackReg) |-> !floatReg && !$past(floatReg))
        else $error("ack high while floated");
    float_late_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(floatReg) |-> $past(state) != MBH_DRIVE)
        else $error("float too early");
    req_sync_a: assert property (@(posedge clk) disable iff (!arst_n)
        reqSync == $past(busReleaseReq_n, 2)) else $error("sync depth");
    // pending changes only on clock rise
    pend_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(pendReg) |-> $rose(clkOut)) else $error("pending off edge");

    hold_seen_c: cover property (@(posedge clk) disable iff (!arst_n)
        $fell(ackReg));
    release_seen_c: cover property (@(posedge clk) disable iff (!arst_n)
        $rose(ackReg));
    clk_float_c: cover property (@(posedge clk) disable iff (!arst_n)
        $fell(memoryClockOutEn));
endmodule : mbh_hold_ctrl

/* File: tb/mbh_master_model.sv */
// external bus master model that borrows the memory bus
module mbh_master_model
#(
    parameter int HOLD_CLKS = 9
)
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic want,
    input  wire logic busReleaseAck_n,
    output logic      busReleaseReq_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int heldClks;
    // request held past ack
    // count must exceed the slowest interface period in use
    always @(negedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busReleaseReq_n <= 1'b1;
            heldClks <= 0;
        end
        else
        begin
            heldClks <= busReleaseAck_n ? 0 : heldClks + 1;
            busReleaseReq_n <= !(want ||
                (!busReleaseAck_n && heldClks < HOLD_CLKS));
        end
    end
endmodule : mbh_master_model

/* File: tb/testbench.sv */
// self-checking bench for the hold handshake controller
module testbench import mbh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [MBH_WIDE_PINS-1:0] NARROW_EN =
        {{(MBH_WIDE_PINS-MBH_NARROW_PINS){1'b0}}, {MBH_NARROW_PINS{1'b1}}};
    logic clk, arst_n, want, busReleaseReq_n, accessPending, accessActive;
    logic sdramAccess, readStrobe, writeStrobe, outputStrobe;
    logic columnStrobe, sdramWriteEnable, rowStrobe, memoryClockOut;
    logic memoryClockOutEn, busDriveEn, busReleaseAck_n;
    logic pendingAccessRequest, prevPend, prevClk;
    logic memoryClockIn = 1'b0;
    logic [MBH_WIDE_PINS-1:0] pinDriveEn;
    mbh_cfg_t  cfg;
    mbh_stat_t status;
    int fail_count = 0;
    int checked = 0;
    int pinDiv = 0;

    mbh_hold_ctrl dut (.clk(clk), .arst_n(arst_n), .cfg(cfg),
        .memoryClockIn(memoryClockIn), .busReleaseReq_n(busReleaseReq_n),
        .accessPending(accessPending), .accessActive(accessActive),
        .sdramAccess(sdramAccess), .readStrobe(readStrobe),
        .writeStrobe(writeStrobe), .outputStrobe(outputStrobe),
        .columnStrobe(columnStrobe), .sdramWriteEnable(sdramWriteEnable),
        .rowStrobe(rowStrobe), .memoryClockOut(memoryClockOut),
        .memoryClockOutEn(memoryClockOutEn), .busDriveEn(busDriveEn),
        .pinDriveEn(pinDriveEn), .busReleaseAck_n(busReleaseAck_n),
        .pendingAccessRequest(pendingAccessRequest), .status(status));
    mbh_master_model master (.clk(clk), .arst_n(arst_n), .want(want),
        .busReleaseAck_n(busReleaseAck_n), .busReleaseReq_n(busReleaseReq_n));

    // core clock, and a pin clock of eight core periods
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk)
    begin
        pinDiv <= (pinDiv + 1) % 4;
        if (pinDiv == 3) memoryClockIn <= ~memoryClockIn;
    end

    task close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic check(input logic [MBH_WIDE_PINS-1:0] seen, exp,
                         input string m);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check

    // bounded wait on bus drive (0), ack (1) or request (2)
    task wait_for(input int sel, input logic val, input int lim,
                  output int n);
        for (n = 0; n <= lim; n++)
        begin
            if ((sel == 0 ? busDriveEn : sel == 1 ? busReleaseAck_n
                 : busReleaseReq_n) === val) return;
            @(negedge clk);
        end
        check(1'b0, 1'b1, "wait ran out");
        close_out();
    endtask : wait_for

    // pending request only moves when the output clock rises
    always @(negedge clk)
    begin
        if (arst_n && pendingAccessRequest !== prevPend)
            check({prevClk, memoryClockOut}, 2'b01, "pending off edge");
        prevPend <= pendingAccessRequest;
        prevClk <= memoryClockOut;
    end

    task t_release(input mbh_src_t src, input logic sel, wide,
                   input int per);
        int n;
        logic c0;
        cfg = '{1'b0, sel, wide, src};
        repeat (2*per) @(negedge clk);
        // non-blocking so the master samples it at the next edge
        want <= 1'b1;
        wait_for(0, 1'b0, 20*per, n);
        check(n >= 2*per, 1'b1, "float early");
        check(pinDriveEn, '0, "pins driven in hold");
        check(busReleaseAck_n, 1'b1, "ack before float");
        check(memoryClockOutEn, !sel, "clock float timing");
        wait_for(1, 1'b0, 3*per, n);
        check(n <= 2*per, 1'b1, "ack late");
        c0 = memoryClockOut;
        repeat (per) @(negedge clk);
        check(memoryClockOutEn, !sel, "clock enable in hold");
        if (!sel)
            check(memoryClockOut, !c0, "clock stopped");
        want <= 1'b0;
        wait_for(2, 1'b1, 3*per, n);
        wait_for(0, 1'b1, 8*per, n);
        check(n >= 2*per && n <= 7*per, 1'b1, "redrive window");
        check(busReleaseAck_n, 1'b0, "ack rose early");
        check(memoryClockOutEn, 1'b1, "clock redrive timing");
        wait_for(1, 1'b1, 3*per, n);
        check(n <= 2*per, 1'b1, "ack high late");
        check(memoryClockOutEn, 1'b1, "clock not redriven");
        check(pinDriveEn, wide ? '1 : NARROW_EN, "pin set");
        $display("release test done");
    endtask : t_release

    task t_drain();
        int n;
        cfg = '{1'b0, 1'b0, 1'b1, MBH_SRC_DIV4};
        accessPending = 1'b1;
        want <= 1'b1;
        repeat (20) @(negedge clk);
        check(pendingAccessRequest, 1'b1, "pending not raised");
        accessPending = 1'b0;
        accessActive = 1'b1;
        repeat (20) @(negedge clk);
        check({busDriveEn, busReleaseAck_n}, 2'b11, "released early");
        accessActive = 1'b0;
        wait_for(1, 1'b0, 40, n);
        check(pendingAccessRequest, 1'b0, "pending not cleared");
        want <= 1'b0;
        wait_for(1, 1'b1, 80, n);
        $display("drain test done");
    endtask : t_drain

    task t_inhibit();
        int n;
        cfg = '{1'b1, 1'b1, 1'b1, MBH_SRC_DIV4};
        want <= 1'b1;
        repeat (80) @(negedge clk);
        check({busDriveEn, busReleaseAck_n}, 2'b11, "inhibit ignored");
        want <= 1'b0;
        repeat (20) @(negedge clk);
        $display("inhibit test done");
    endtask : t_inhibit

    task t_strobes();
        for (int i = 0; i < 16; i++)
        begin
            {sdramAccess, readStrobe, writeStrobe, outputStrobe} = 4'(i);
            #1;
            check({columnStrobe, sdramWriteEnable, rowStrobe},
                  sdramAccess ? {readStrobe, writeStrobe, outputStrobe}
                  : 3'h7, "strobe map");
        end
        $display("strobe test done");
    endtask : t_strobes

    // reset, then the scenarios in turn
    initial
    begin
        {arst_n, want, accessPending, accessActive} = 4'h0;
        {sdramAccess, readStrobe, writeStrobe, outputStrobe} = 4'h0;
        cfg = '{1'b0, 1'b0, 1'b1, MBH_SRC_DIV4};
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        check({busDriveEn, busReleaseAck_n, memoryClockOutEn,
               pendingAccessRequest}, 4'hE, "reset state");
        t_release(MBH_SRC_DIV4, 1'b1, 1'b1, 4);
        t_release(MBH_SRC_DIV6, 1'b0, 1'b0, 6);
        t_release(MBH_SRC_PIN, 1'b1, 1'b0, 8);
        t_drain();
        t_inhibit();
        t_strobes();
        close_out();
    end
endmodule : testbench
